// ### core/gpp_pkg.sv
// types shared by the port block
// assumes nothing beyond the register header
package gpp_pkg;
  typedef logic [7:0] gpp_byte_t;
  typedef enum logic [1:0] {
    GPP_IDLE = 2'b01,
    GPP_ACCESS = 2'b10
  } gpp_phase_e;
endpackage

// ### core/gpp_port.sv
// eight-pin general purpose port with apb register slave and edge/level interrupt
// assumes pclk at 250 MHz, pins asynchronous to pclk, pads resolve the three-signal pins
module gpp_port #(
  parameter logic [7:0] ALT_RESET = 8'h00,
  parameter logic [7:0] BONDED = 8'hff
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  // peripheral alternate function
  input wire logic [7:0] periph_out,
  input wire logic [7:0] periph_oe,
  output logic [7:0] periph_in,
  // pad configuration
  output logic [7:0] drive_low_select,
  output logic [7:0] drive_mid_select,
  output logic [7:0] drive_high_select,
  output logic [7:0] open_drain_select,
  output logic [7:0] pull_up_select,
  output logic [7:0] pull_down_select,
  output logic [7:0] slew_limit_select,
  output logic [7:0] digital_input_enable,
  // interrupt to controller
  output logic port_irq
);
`include "gpp_regs.svh"

  gpp_pkg::gpp_byte_t port_data_value;
  gpp_pkg::gpp_byte_t pin_direction;
  gpp_pkg::gpp_byte_t alt_function_select;
  gpp_pkg::gpp_byte_t irq_sense_select;
  gpp_pkg::gpp_byte_t irq_dual_edge_select;
  gpp_pkg::gpp_byte_t irq_event_polarity;
  gpp_pkg::gpp_byte_t irq_mask_bits;
  gpp_pkg::gpp_byte_t edge_latch;
  gpp_pkg::gpp_byte_t sync_a;
  gpp_pkg::gpp_byte_t sync_b;
  gpp_pkg::gpp_byte_t sync_prev;
  gpp_pkg::gpp_byte_t irq_raw_status;
  gpp_pkg::gpp_byte_t irq_masked_status;
  gpp_pkg::gpp_byte_t edge_hit;
  gpp_pkg::gpp_byte_t level_hit;
  gpp_pkg::gpp_byte_t data_mask;
  gpp_pkg::gpp_byte_t wbyte;
  gpp_pkg::gpp_byte_t clr_req;
  gpp_pkg::gpp_phase_e phase;
  logic setup;
  logic wr_go;
  logic rd_go;
  logic is_data;
  logic [31:0] next_prdata;
  logic next_slverr;

  // masked update: only bits selected by mask take the new value
  function automatic gpp_pkg::gpp_byte_t merge(input gpp_pkg::gpp_byte_t old,
                                               input gpp_pkg::gpp_byte_t nw,
                                               input gpp_pkg::gpp_byte_t m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // register address hit for a given offset
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // bus phase decode; reads are looked up at setup, writes commit on the completing access edge
  assign setup = psel && !penable;
  assign wr_go = psel && penable && pwrite && pready;
  assign rd_go = setup && !pwrite;
  assign is_data = (paddr[11:10] == 2'b00);
  assign data_mask = paddr[`GPP_DATA_MASK_HI:`GPP_DATA_MASK_LO];
  assign wbyte = pwdata[7:0];

  // two-stage pin synchroniser and previous sample
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a <= `GPP_RST_ZERO;
      sync_b <= `GPP_RST_ZERO;
      sync_prev <= `GPP_RST_ZERO;
    end
    else
    begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end

  // edge and level condition per pin
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      level_hit[i] = (sync_b[i] == irq_event_polarity[i]);
      if (irq_dual_edge_select[i])
        edge_hit[i] = sync_b[i] ^ sync_prev[i];
      else if (irq_event_polarity[i])
        edge_hit[i] = sync_b[i] & ~sync_prev[i];
      else
        edge_hit[i] = ~sync_b[i] & sync_prev[i];
    end
  end

  // clear request from a clear-location write
  assign clr_req = (wr_go && hit(paddr, `GPP_OFF_CLR)) ? (wbyte & BONDED) : 8'h00;

  // latched edge status, a new edge wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      edge_latch <= `GPP_RST_ZERO;
    else
      edge_latch <= ((edge_latch & ~clr_req) | edge_hit) & ~irq_sense_select & BONDED;
  end

  // raw and masked status
  always_comb
  begin
    irq_raw_status = (irq_sense_select & level_hit & BONDED) | edge_latch;
    irq_masked_status = irq_raw_status & irq_mask_bits;
  end

  // combined interrupt output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_irq <= 1'b0;
    else
      port_irq <= |irq_masked_status;
  end

  // port data: inputs follow the pins, outputs keep software writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_data_value <= `GPP_RST_ZERO;
    else if (wr_go && is_data)
      port_data_value <= merge(merge(port_data_value, sync_b, ~pin_direction), wbyte,
                               data_mask & pin_direction & BONDED);
    else
      port_data_value <= merge(port_data_value, sync_b, ~pin_direction);
  end

  // direction, mode and interrupt configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_direction <= `GPP_RST_ZERO;
      alt_function_select <= ALT_RESET;
      irq_sense_select <= `GPP_RST_ZERO;
      irq_dual_edge_select <= `GPP_RST_ZERO;
      irq_event_polarity <= `GPP_RST_ZERO;
      irq_mask_bits <= `GPP_RST_ZERO;
    end
    else if (wr_go)
    begin
      if (hit(paddr, `GPP_OFF_DIR))
        pin_direction <= merge(pin_direction, wbyte, BONDED);
      else if (hit(paddr, `GPP_OFF_ALT))
        alt_function_select <= merge(alt_function_select, wbyte, BONDED);
      else if (hit(paddr, `GPP_OFF_SENSE))
        irq_sense_select <= merge(irq_sense_select, wbyte, BONDED);
      else if (hit(paddr, `GPP_OFF_DUAL))
        irq_dual_edge_select <= merge(irq_dual_edge_select, wbyte, BONDED);
      else if (hit(paddr, `GPP_OFF_POL))
        irq_event_polarity <= merge(irq_event_polarity, wbyte, BONDED);
      else if (hit(paddr, `GPP_OFF_MASK))
        irq_mask_bits <= merge(irq_mask_bits, wbyte, BONDED);
    end
  end

  // pad configuration storage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive_low_select <= `GPP_RST_ONES;
      drive_mid_select <= `GPP_RST_ZERO;
      drive_high_select <= `GPP_RST_ZERO;
      open_drain_select <= `GPP_RST_ZERO;
      pull_up_select <= `GPP_RST_ONES;
      pull_down_select <= `GPP_RST_ZERO;
      slew_limit_select <= `GPP_RST_ZERO;
      digital_input_enable <= `GPP_RST_ONES;
    end
    else if (wr_go)
    begin
      if (hit(paddr, `GPP_OFF_DR2))
        drive_low_select <= merge(drive_low_select, wbyte, BONDED);
      else if (hit(paddr, `GPP_OFF_DR4))
        drive_mid_select <= merge(drive_mid_select, wbyte, BONDED);
      else if (hit(paddr, `GPP_OFF_DR8))
        drive_high_select <= merge(drive_high_select, wbyte, BONDED);
      else if (hit(paddr, `GPP_OFF_ODR))
        open_drain_select <= merge(open_drain_select, wbyte, BONDED);
      else if (hit(paddr, `GPP_OFF_PUR))
        pull_up_select <= merge(pull_up_select, wbyte, BONDED);
      else if (hit(paddr, `GPP_OFF_PDR))
        pull_down_select <= merge(pull_down_select, wbyte, BONDED);
      else if (hit(paddr, `GPP_OFF_SLR))
        slew_limit_select <= merge(slew_limit_select, wbyte, BONDED);
      else if (hit(paddr, `GPP_OFF_DEN))
        digital_input_enable <= merge(digital_input_enable, wbyte, BONDED);
    end
  end

  // pin muxing between software and peripheral, registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= `GPP_RST_ZERO;
      pin_oe <= `GPP_RST_ZERO;
      periph_in <= `GPP_RST_ZERO;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (alt_function_select[i])
        begin
          pin_out[i] <= periph_out[i];
          pin_oe[i] <= periph_oe[i];
        end
        else
        begin
          pin_out[i] <= port_data_value[i];
          pin_oe[i] <= pin_direction[i];
        end
      end
      periph_in <= sync_b & alt_function_select;
    end
  end

  // read decode
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    if (is_data)
      next_prdata[7:0] = port_data_value & data_mask;
    else if (hit(paddr, `GPP_OFF_DIR))
      next_prdata[7:0] = pin_direction;
    else if (hit(paddr, `GPP_OFF_SENSE))
      next_prdata[7:0] = irq_sense_select;
    else if (hit(paddr, `GPP_OFF_DUAL))
      next_prdata[7:0] = irq_dual_edge_select;
    else if (hit(paddr, `GPP_OFF_POL))
      next_prdata[7:0] = irq_event_polarity;
    else if (hit(paddr, `GPP_OFF_MASK))
      next_prdata[7:0] = irq_mask_bits;
    else if (hit(paddr, `GPP_OFF_RAW))
      next_prdata[7:0] = irq_raw_status;
    else if (hit(paddr, `GPP_OFF_MSTAT))
      next_prdata[7:0] = irq_masked_status;
    else if (hit(paddr, `GPP_OFF_CLR))
      next_prdata[7:0] = 8'h00;
    else if (hit(paddr, `GPP_OFF_ALT))
      next_prdata[7:0] = alt_function_select;
    else if (hit(paddr, `GPP_OFF_DR2))
      next_prdata[7:0] = drive_low_select;
    else if (hit(paddr, `GPP_OFF_DR4))
      next_prdata[7:0] = drive_mid_select;
    else if (hit(paddr, `GPP_OFF_DR8))
      next_prdata[7:0] = drive_high_select;
    else if (hit(paddr, `GPP_OFF_ODR))
      next_prdata[7:0] = open_drain_select;
    else if (hit(paddr, `GPP_OFF_PUR))
      next_prdata[7:0] = pull_up_select;
    else if (hit(paddr, `GPP_OFF_PDR))
      next_prdata[7:0] = pull_down_select;
    else if (hit(paddr, `GPP_OFF_SLR))
      next_prdata[7:0] = slew_limit_select;
    else if (hit(paddr, `GPP_OFF_DEN))
      next_prdata[7:0] = digital_input_enable;
    else
      next_slverr = 1'b1; // unmapped offset
  end

  // apb answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= gpp_pkg::GPP_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      case (phase)
        gpp_pkg::GPP_IDLE:
        begin
          pready <= setup;
          pslverr <= setup && next_slverr;
          if (rd_go)
            prdata <= next_prdata;
          if (setup)
            phase <= gpp_pkg::GPP_ACCESS;
        end
        gpp_pkg::GPP_ACCESS:
        begin
          pready <= 1'b0;
          pslverr <= 1'b0;
          phase <= gpp_pkg::GPP_IDLE;
        end
        default:
          phase <= gpp_pkg::GPP_IDLE;
      endcase
    end
  end

  // checks
  rst_alt_a: assert property (@(posedge pclk) $rose(presetn) |-> alt_function_select == ALT_RESET && pin_direction == 8'h00)
    else $error("alternate select or direction not at reset value");
  rst_test_a: assert property (@(posedge pclk) !presetn |=> pin_oe == 8'h00)
    else $error("pins driven during reset");
  sequence data_wr_s;
    wr_go && is_data;
  endsequence
  data_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    data_wr_s |=> ((port_data_value ^ $past(port_data_value)) & $past(data_mask) & $past(pin_direction)) ==
                  ((($past(wbyte) ^ $past(port_data_value))) & $past(data_mask) & $past(pin_direction) & BONDED))
    else $error("masked data write wrong");
  read_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_go && is_data |=> (prdata[7:0] & ~$past(data_mask)) == 8'h00 && prdata[31:8] == 24'h0)
    else $error("masked read bits not zero");
  input_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((port_data_value ^ $past(sync_b)) & ~$past(pin_direction)) == 8'h00)
    else $error("input bit did not capture pin");
  out_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((pin_oe ^ $past(pin_direction)) & ~$past(alt_function_select)) == 8'h00)
    else $error("output enable does not follow direction");
  irq_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> port_irq == $past(|irq_masked_status))
    else $error("interrupt output mismatch");
  edge_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_latch != 8'h00) && !(wr_go && hit(paddr, `GPP_OFF_CLR)) && $stable(irq_sense_select)
      |=> (($past(edge_latch) & ~edge_latch) == 8'h00))
    else $error("edge latch lost without clear");
  clr_eff_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_go && hit(paddr, `GPP_OFF_CLR) && edge_hit == 8'h00 |=> (edge_latch & $past(clr_req)) == 8'h00)
    else $error("clear did not clear");
  mstat_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_masked_status == (irq_raw_status & irq_mask_bits))
    else $error("masked status mismatch");
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && phase == gpp_pkg::GPP_IDLE |=> pready ##1 !pready)
    else $error("ready not single cycle after setup");
endmodule

// ### core/gpp_regs.svh
// register offsets, reset values and timing constants for the eight-pin port
// assumes byte addresses on a 32-bit apb bus, 12 address bits decoded
`ifndef GPP_REGS_SVH
`define GPP_REGS_SVH
`define GPP_DATA_MASK_HI 9
`define GPP_DATA_MASK_LO 2
`define GPP_OFF_DIR 12'h400
`define GPP_OFF_SENSE 12'h404
`define GPP_OFF_DUAL 12'h408
`define GPP_OFF_POL 12'h40c
`define GPP_OFF_MASK 12'h410
`define GPP_OFF_RAW 12'h414
`define GPP_OFF_MSTAT 12'h418
`define GPP_OFF_CLR 12'h41c
`define GPP_OFF_ALT 12'h420
`define GPP_OFF_DR2 12'h500
`define GPP_OFF_DR4 12'h504
`define GPP_OFF_DR8 12'h508
`define GPP_OFF_ODR 12'h50c
`define GPP_OFF_PUR 12'h510
`define GPP_OFF_PDR 12'h514
`define GPP_OFF_SLR 12'h518
`define GPP_OFF_DEN 12'h51c
`define GPP_RST_ZERO 8'h00
`define GPP_RST_ONES 8'hff
`define GPP_CLK_WAIT_CYC 3
`endif

// ### dv/gpp_pin_model.sv
// pad and far-side source model for the eight-pin port
// assumes the bench supplies the source level and whether the source drives
module gpp_pin_model (
  // block side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pull_up_select,
  output logic [7:0] pin_in,
  // far-side source
  input wire logic [7:0] ext_level,
  input wire logic ext_en
);
  timeunit 1ns;
  timeprecision 1ps;

  // block driver wins, then the source, then the pull; a floating pin without a pull-up takes the inverse of the source level
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en)
        pin_in[i] = ext_level[i]; // source keeps its level until serviced
      else
        pin_in[i] = pull_up_select[i] | ~ext_level[i];
    end
  end
endmodule

// ### dv/gpp_port_tb_top.sv
// self-checking bench for the eight-pin port: apb reads are queued and compared by a monitor
// assumes the register header, a 4 ns pclk and the pad model beside the block
`include "gpp_regs.svh"
module gpp_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] OFFS [14] = '{`GPP_OFF_DIR, `GPP_OFF_SENSE, `GPP_OFF_DUAL, `GPP_OFF_POL,
    `GPP_OFF_MASK, `GPP_OFF_ALT, `GPP_OFF_DR2, `GPP_OFF_DR4, `GPP_OFF_DR8, `GPP_OFF_ODR,
    `GPP_OFF_PUR, `GPP_OFF_PDR, `GPP_OFF_SLR, `GPP_OFF_DEN};
  localparam logic [7:0] RSTV [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'hff,
    8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] periph_out = 8'h00;
  logic [7:0] periph_oe = 8'h00;
  logic [7:0] ext_level = 8'h00;
  logic ext_en = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, port_irq;
  logic [7:0] pin_in, pin_out, pin_oe, periph_in, dls, dms, dhs, ods, pus, pds, sls, die;
  logic [32:0] exp_q [$];
  logic [7:0] v [14];
  logic [7:0] m, d, cur;
  int seed = 8;
  int num_errors = 0;
  int check_count = 0;

  gpp_port #(.ALT_RESET(8'h80), .BONDED(8'hff)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out),
    .periph_oe(periph_oe), .periph_in(periph_in), .drive_low_select(dls), .drive_mid_select(dms),
    .drive_high_select(dhs), .open_drain_select(ods), .pull_up_select(pus), .pull_down_select(pds),
    .slew_limit_select(sls), .digital_input_enable(die), .port_irq(port_irq));

  gpp_pin_model u_pad (.pin_out(pin_out), .pin_oe(pin_oe), .pull_up_select(pus), .pin_in(pin_in),
    .ext_level(ext_level), .ext_en(ext_en));

  // clock
  always #2 pclk = ~pclk;

  task automatic chk(input string name, input logic [63:0] e, input logic [63:0] s);
    check_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one apb transfer: setup, access held until pready, release, one idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // monitor: oldest queued expectation against each completed read
  always @(posedge pclk)
  begin
    if (psel & penable & ~pwrite & (pready === 1'b1) & (exp_q.size() > 0))
      chk("prdata", {31'h0, exp_q.pop_front()}, {31'h0, pslverr, prdata});
  end

  // watchdog
  initial
  begin
    #200000;
    num_errors++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    wait_cyc(20);
    presetn <= 1'b1;
    @(posedge pclk);
    wait_cyc(`GPP_CLK_WAIT_CYC);
    // reset values, then random write and readback of every configuration and pad register
    for (int i = 0; i < 14; i++)
    begin
      rd(OFFS[i], {25'h0, RSTV[i]});
      v[i] = 8'($random(seed));
      wr(OFFS[i], {24'h0, v[i]});
      rd(OFFS[i], {25'h0, v[i]});
    end
    chk("pad", {v[6], v[7], v[8], v[9], v[10], v[11], v[12], v[13]}, {dls, dms, dhs, ods, pus, pds, sls, die});
    // address-masked data access with all pins as outputs
    wr(`GPP_OFF_MASK, 32'h0);
    wr(`GPP_OFF_ALT, 32'h0);
    wr(`GPP_OFF_DIR, 32'hff);
    wr(12'h3fc, 32'h0);
    wr(12'h098, 32'heb);
    rd(12'h3fc, 33'h22);
    rd(12'h0c4, 33'h20);
    chk("pin_oe", 8'hff, pin_oe);
    chk("pin_out", 8'h22, pin_out);
    cur = 8'h22;
    for (int i = 0; i < 6; i++)
    begin
      m = 8'($random(seed));
      d = 8'($random(seed));
      cur = (cur & ~m) | (d & m);
      wr({2'b00, m, 2'b00}, {24'h0, d});
      rd({2'b00, ~m, 2'b00}, {25'h0, cur & ~m});
      rd(12'h3fc, {25'h0, cur});
    end
    rd(12'h600, 33'h100000000);
    // input capture
    wr(`GPP_OFF_DIR, 32'h0);
    ext_level <= 8'($random(seed));
    wait_cyc(5);
    rd(12'h3fc, {25'h0, ext_level});
    // source released: undriven pins float to the pull-up or, without one, the inverse level
    ext_en <= 1'b0;
    wait_cyc(5);
    rd(12'h3fc, {25'h0, v[10] | ~ext_level});
    ext_en <= 1'b1;
    // alternate function on the low nibble
    wr(`GPP_OFF_ALT, 32'h0f);
    periph_out <= 8'($random(seed));
    periph_oe <= 8'($random(seed));
    wait_cyc(5);
    chk("pin_oe", {4'h0, periph_oe[3:0]}, pin_oe);
    chk("pin_out", periph_out & periph_oe & 8'h0f, pin_out & pin_oe);
    chk("periph_in", ((periph_oe & periph_out) | (~periph_oe & ext_level)) & 8'h0f, periph_in);
    // interrupts: b0 rise, b1 fall, b2 both, b3 high level, b4 low level; masked while set up
    wr(`GPP_OFF_ALT, 32'h0);
    ext_level <= 8'h00;
    wr(`GPP_OFF_SENSE, 32'h18);
    wr(`GPP_OFF_DUAL, 32'h04);
    wr(`GPP_OFF_POL, 32'h09);
    wait_cyc(6);
    wr(`GPP_OFF_CLR, 32'hff);
    rd(`GPP_OFF_RAW, 33'h10);
    ext_level <= 8'h1f;
    wait_cyc(6);
    rd(`GPP_OFF_RAW, 33'h0d);
    ext_level <= 8'h00;
    wait_cyc(6);
    rd(`GPP_OFF_RAW, 33'h17);
    wr(`GPP_OFF_MASK, 32'h02);
    wait_cyc(3);
    chk("port_irq", 1'b1, port_irq);
    rd(`GPP_OFF_MSTAT, 33'h02);
    wr(`GPP_OFF_CLR, 32'h00);
    rd(`GPP_OFF_RAW, 33'h17);
    wr(`GPP_OFF_CLR, 32'h02);
    rd(`GPP_OFF_RAW, 33'h15);
    rd(`GPP_OFF_MSTAT, 33'h00);
    chk("port_irq", 1'b0, port_irq);
    wr(`GPP_OFF_MASK, 32'h10);
    wait_cyc(3);
    chk("port_irq", 1'b1, port_irq);
    ext_level <= 8'h10;
    wait_cyc(6);
    rd(`GPP_OFF_RAW, 33'h05);
    chk("port_irq", 1'b0, port_irq);
    // reset in mid-run restores defaults
    presetn <= 1'b0;
    wait_cyc(2);
    presetn <= 1'b1;
    @(posedge pclk);
    wait_cyc(`GPP_CLK_WAIT_CYC);
    rd(`GPP_OFF_ALT, 33'h80);
    rd(`GPP_OFF_DIR, 33'h00);
    wait_cyc(2);
    wrap_up();
  end
endmodule
